// ===== hdl/umpf_defines.vh
`ifndef UMPF_DEFINES_VH
`define UMPF_DEFINES_VH
// character size codes
`define UMPF_CSZ_5 3'h0
`define UMPF_CSZ_6 3'h1
`define UMPF_CSZ_7 3'h2
`define UMPF_CSZ_8 3'h3
`define UMPF_CSZ_9 3'h7
// field positions inside the captured frame word
`define UMPF_NINTH_POS 8
// reset values
`define UMPF_FILTER_RST 1'b0
`define UMPF_CSZ_RST 3'h3
`endif

// ===== hdl/umpf_filter.v
// Notes on behaviour
// - filter on: data frames dropped, buffer untouched
// - transmit path ignores the filter setting
// - sizes 5 to 8: first stop marks type
// - size nine: ninth data bit marks type
// - marker one is address, zero is data
// - address frames stored and flagged as normal
// - filter off accepts data; filter on waits
// - one character size shared by rx and tx
// - writing one clears tx complete; interrupt too
// - ninth bit readable separately, read it first
`include "umpf_defines.vh"
`default_nettype none
module umpf_filter #(
    parameter DATA_W = 9
) (
    input wire mclk_i,
    input wire rst_i,
    // configuration bits
    input wire addr_filter_enable_wr_i,
    input wire addr_filter_enable_val_i,
    input wire [2:0] char_size_code_i,
    // frame from the receive shifter, one-cycle strobe
    input wire rx_frame_valid_i,
    input wire [DATA_W-1:0] rx_frame_data_i,
    input wire rx_first_stop_i,
    // software read of the data register
    input wire serial_data_rd_i,
    // transmit side events
    input wire tx_done_i,
    input wire tx_complete_clr_wr_i,
    input wire tx_int_ack_i,
    input wire [DATA_W-1:0] tx_data_i,
    input wire tx_ninth_bit_i,
    output wire [2:0] tx_char_size_code_o,
    output reg [DATA_W-1:0] tx_frame_o,
    output reg addr_filter_enable_o,
    output reg [7:0] serial_data_reg_o,
    output reg rx_ninth_bit_o,
    output reg rx_complete_flag_o,
    output reg tx_complete_flag_o,
    output wire frame_dropped_o
);

// size codes as named words, so the decode below reads plainly
localparam [2:0] SIZE_5 = `UMPF_CSZ_5;
localparam [2:0] SIZE_6 = `UMPF_CSZ_6;
localparam [2:0] SIZE_7 = `UMPF_CSZ_7;
localparam [2:0] SIZE_8 = `UMPF_CSZ_8;
localparam [2:0] SIZE_9 = `UMPF_CSZ_9;

// frame classification, all combinational in the strobe cycle
wire is_nine;
wire is_short;
wire type_marker;
wire is_address;
wire keep_frame;

// captured character with unused upper bits cleared
reg [7:0] data_masked;

// next values of every stored output
reg [7:0] rx_data_nxt;
reg rx_ninth_nxt;
reg rx_complete_nxt;
reg filter_nxt;
reg tx_complete_nxt;
reg [DATA_W-1:0] tx_frame_nxt;

// one size setting serves both directions
// a size change for reception therefore also retimes transmission
assign tx_char_size_code_o = char_size_code_i;

// nine-bit mode is the only one whose marker lives in the data word
assign is_nine = (char_size_code_i == SIZE_9);
assign is_short = ~is_nine;

// marker chosen by size; only the first stop bit is ever used
// a second stop bit, if the sender has one, never reaches this block
assign type_marker = is_nine ? rx_frame_data_i[`UMPF_NINTH_POS]
                             : rx_first_stop_i;

// marker high means address, low means data
assign is_address = (type_marker == 1'h1);

// decision made in the strobe cycle, before the buffer edge
// the marker is already part of the strobed word, so no wait is needed
assign keep_frame = rx_frame_valid_i & (is_address | ~addr_filter_enable_o);

// pulse for the cycle of a refused frame only
assign frame_dropped_o = rx_frame_valid_i & ~keep_frame;

// unused upper bits read as zero for short characters
// codes between eight and nine are not legal; they fall back to eight bits
always @* begin
    case (char_size_code_i)
        SIZE_5: begin
            data_masked = {3'h0, rx_frame_data_i[4:0]};
        end
        SIZE_6: begin
            data_masked = {2'h0, rx_frame_data_i[5:0]};
        end
        SIZE_7: begin
            data_masked = {1'h0, rx_frame_data_i[6:0]};
        end
        SIZE_8: begin
            data_masked = rx_frame_data_i[7:0];
        end
        default: begin
            data_masked = rx_frame_data_i[7:0];
        end
    endcase
end

// software alone owns the filter bit; hardware never changes it
// a dedicated write strobe keeps this bit apart from the flag clears
always @* begin
    filter_nxt = addr_filter_enable_o;
    if (addr_filter_enable_wr_i) begin
        filter_nxt = addr_filter_enable_val_i;
    end
end

// filter bit register; a write takes effect from the next cycle
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        addr_filter_enable_o <= `UMPF_FILTER_RST;
    end else begin
        addr_filter_enable_o <= filter_nxt;
    end
end

// receive buffer next values: dropped frames leave data and flag alone
// a kept frame and a read in one cycle leave the flag set, so no frame is lost
always @* begin
    rx_data_nxt = serial_data_reg_o;
    rx_ninth_nxt = rx_ninth_bit_o;
    rx_complete_nxt = rx_complete_flag_o;
    if (keep_frame) begin
        rx_data_nxt = data_masked;
        rx_ninth_nxt = is_nine & rx_frame_data_i[`UMPF_NINTH_POS];
        rx_complete_nxt = 1'h1; // set wins over read
    end else if (serial_data_rd_i) begin
        rx_complete_nxt = 1'h0;
    end
end

// receive buffer registers
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        serial_data_reg_o <= 8'h00;
        rx_ninth_bit_o <= 1'h0;
        rx_complete_flag_o <= 1'h0;
    end else begin
        serial_data_reg_o <= rx_data_nxt;
        rx_ninth_bit_o <= rx_ninth_nxt;
        rx_complete_flag_o <= rx_complete_nxt;
    end
end

// transmit word: filter bit deliberately not an input here
// short characters send no ninth bit, so it is forced low
always @* begin
    tx_frame_nxt = {DATA_W{1'h0}};
    tx_frame_nxt[7:0] = tx_data_i[7:0];
    tx_frame_nxt[`UMPF_NINTH_POS] = tx_ninth_bit_i & ~is_short;
end

// transmit word register
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        tx_frame_o <= {DATA_W{1'h0}};
    end else begin
        tx_frame_o <= tx_frame_nxt;
    end
end

// tx complete next value: set wins over a clear in the same cycle
// losing the set would hide a finished frame from software
always @* begin
    tx_complete_nxt = tx_complete_flag_o;
    if (tx_done_i) begin
        tx_complete_nxt = 1'h1;
    end else if (tx_complete_clr_wr_i | tx_int_ack_i) begin
        tx_complete_nxt = 1'h0;
    end
end

// tx complete register
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        tx_complete_flag_o <= 1'h0;
    end else begin
        tx_complete_flag_o <= tx_complete_nxt;
    end
end

endmodule // umpf_filter
`default_nettype wire

// ===== bench/umpf_props.sv
`default_nettype none
module umpf_props (
    input wire logic mclk_i, rst_i, rx_frame_valid_i, rx_first_stop_i, addr_filter_enable_o,
    input wire logic frame_dropped_o, rx_complete_flag_o, rx_ninth_bit_o,
    input wire logic [2:0] char_size_code_i,
    input wire logic [8:0] rx_frame_data_i,
    input wire logic [7:0] serial_data_reg_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // keep decision rebuilt from marker and filter
    wire n = char_size_code_i == 3'h7;
    wire v = rx_frame_valid_i;
    wire m = n ? rx_frame_data_i[8] : rx_first_stop_i;
    wire k = m | ~addr_filter_enable_o;
    sequence s_keep; v && k; endsequence
    a_drop_data: assert property (v && !k |-> frame_dropped_o ##1 $stable(serial_data_reg_o))
        else $error("drop");
    a_keep_flag: assert property (s_keep |=> rx_complete_flag_o) else $error("flag");
    a_nine_mark: assert property (s_keep ##0 n |=>
        {rx_ninth_bit_o, serial_data_reg_o} == $past(rx_frame_data_i)) else $error("nine");
    a_stop_mark: assert property (v && !n && m |-> !frame_dropped_o) else $error("stop");
    a_zero_data: assert property (v && !m && addr_filter_enable_o |-> frame_dropped_o)
        else $error("zero");
    a_filter_off: assert property (v && !addr_filter_enable_o |->
        !frame_dropped_o ##1 rx_complete_flag_o) else $error("off");
    a_idle_quiet: assert property (!v |-> !frame_dropped_o) else $error("idle");
    a_keep_once: assert property (s_keep |-> !frame_dropped_o) else $error("kept");
endmodule // umpf_props
bind umpf_filter umpf_props chk (.*);
`default_nettype wire

// ===== bench/umpf_master.sv
`default_nettype none
module umpf_master (
    input wire logic mclk_i, go_i, addr_i, nine_i,
    input wire logic [7:0] byte_i,
    output logic valid_o, stop_o,
    output logic [8:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic t = 1'h0;
    // idle lines toggle so a stale frame never looks valid
    always @(negedge mclk_i) t <= ~t;
    assign valid_o = go_i;
    assign data_o = go_i ? {nine_i & addr_i, byte_i} : {9{t}};
    assign stop_o = go_i ? nine_i | addr_i : t;
endmodule // umpf_master
`default_nettype wire

// ===== bench/umpf_filter_test.sv
`default_nettype none
module umpf_filter_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'h0, rst_i = 1'h1, go, ad, ef, erc, etc, en, addr_filter_enable_wr_i;
    logic addr_filter_enable_val_i, serial_data_rd_i, tx_done_i, tx_complete_clr_wr_i;
    logic tx_int_ack_i, tx_ninth_bit_i, rx_frame_valid_i, rx_first_stop_i, rx_ninth_bit_o;
    logic rx_complete_flag_o, tx_complete_flag_o, addr_filter_enable_o, frame_dropped_o;
    logic [2:0] char_size_code_i, tx_char_size_code_o;
    logic [7:0] serial_data_reg_o, by, ed;
    logic [8:0] rx_frame_data_i, tx_data_i, tx_frame_o, etf;
    logic [31:0] r;
    integer seed = 79440, fail_count = 0, checked = 0, i;
    always #4 mclk_i = ~mclk_i;
    umpf_filter dut (.*);
    umpf_master far (.mclk_i(mclk_i), .go_i(go), .addr_i(ad), .nine_i(char_size_code_i[2]),
        .byte_i(by), .valid_o(rx_frame_valid_i), .stop_o(rx_first_stop_i), .data_o(rx_frame_data_i));
    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one cycle: apply inputs, update the expected model, compare after the edge
    task automatic step(input logic [31:0] v);
        {addr_filter_enable_wr_i, addr_filter_enable_val_i, go, ad, serial_data_rd_i} = v[4:0];
        {tx_done_i, tx_complete_clr_wr_i, tx_int_ack_i, tx_ninth_bit_i, by} = v[19:8];
        tx_data_i = v[31:23];
        char_size_code_i = v[7] ? 3'h7 : {1'h0, v[6:5]};
        if (rst_i) repeat (5) @(negedge mclk_i);
        rst_i = 1'h0;
        if (go && (ad || !ef)) begin
            {en, erc} = {char_size_code_i[2] & ad, 1'h1};
            ed = by & (8'hff >> (2'h3 - char_size_code_i[1:0]));
        end else if (serial_data_rd_i) erc = 1'h0;
        etc = tx_done_i | (etc & ~tx_complete_clr_wr_i & ~tx_int_ack_i);
        etf = {tx_ninth_bit_i & char_size_code_i[2], tx_data_i[7:0]};
        if (addr_filter_enable_wr_i) ef = addr_filter_enable_val_i;
        @(negedge mclk_i);
        cmp({rx_ninth_bit_o, serial_data_reg_o}, {en, ed});
        cmp({rx_complete_flag_o, tx_complete_flag_o, addr_filter_enable_o}, {erc, etc, ef});
        cmp(tx_frame_o, etf);
        cmp(tx_char_size_code_o, char_size_code_i);
        cmp(frame_dropped_o, go & ~ad & ef);
    endtask
    task automatic final_report;
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // directed slave exchange first, then random frames, sizes and flag events
    initial begin
        {ef, erc, etc, en, ed, etf} = '0;
        step(32'h0000_0098);
        step(32'h0000_5584);
        step(32'h0000_2A86);
        step(32'h0000_0091);
        step(32'h0000_3C84);
        step(32'h0000_0098);
        step(32'h0000_5504);
        step(32'h0000_FF06);
        step(32'h000C_0000);
        $display("directed test done");
        for (i = 0; i < 2000; i++) begin
            r = $random(seed);
            step(r);
        end
        $display("random test done");
        final_report;
    end
    // about 2015 cycles of 8 ns are needed; allow some margin
    initial begin
        #20000;
        fail_count++;
        final_report;
    end
endmodule // umpf_filter_test
`default_nettype wire
